//--- verilog/compact_timer_pkg.sv
package compact_timer_pkg;
    // Widths
    localparam int CNT_W = 10;
    localparam int PER_W = 3;
    localparam int PRE_W = 6;
    localparam int LOW_BITS = 7;

    // Register byte offsets on the bus
    localparam logic [7:0] OFF_CTRL0 = 8'h00;
    localparam logic [7:0] OFF_CTRL1 = 8'h04;
    localparam logic [7:0] OFF_CNT_LO = 8'h08;
    localparam logic [7:0] OFF_CNT_HI = 8'h0C;
    localparam logic [7:0] OFF_CMPA_LO = 8'h10;
    localparam logic [7:0] OFF_CMPA_HI = 8'h14;
    localparam logic [7:0] OFF_FLAGS = 8'h18;

    // Control 0 fields
    localparam int C0_PAUSE = 7;
    localparam int C0_CKS_HI = 6;
    localparam int C0_CKS_LO = 4;
    localparam int C0_ON = 3;
    localparam int C0_PER_HI = 2;

    // Control 1 fields
    localparam int C1_MODE_HI = 7;
    localparam int C1_MODE_LO = 6;
    localparam int C1_PF_HI = 5;
    localparam int C1_PF_LO = 4;
    localparam int C1_OC = 3;
    localparam int C1_POL = 2;
    localparam int C1_DPX = 1;
    localparam int C1_CCLR = 0;

    // Flag register bits
    localparam int FL_A = 0;
    localparam int FL_P = 1;

    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [9:0] CNT_RST = 10'h000;

    // Operating modes
    typedef enum logic [1:0] {
        MODE_CMP = 2'b00,
        MODE_UNDEF = 2'b01,
        MODE_PWM = 2'b10,
        MODE_TMR = 2'b11
    } mode_t;

    // Pin functions
    localparam logic [1:0] PF_NONE = 2'b00;
    localparam logic [1:0] PF_LOW = 2'b01;
    localparam logic [1:0] PF_HIGH = 2'b10;
    localparam logic [1:0] PF_TOGGLE = 2'b11;
    localparam logic [1:0] PF_INACT = 2'b00;
    localparam logic [1:0] PF_ACT = 2'b01;
    localparam logic [1:0] PF_PWM = 2'b10;

    // Counter clock dividers (terminal counts, divide minus one)
    localparam logic [5:0] DIV4_TC = 6'h03;
    localparam logic [5:0] DIV1_TC = 6'h00;
    localparam logic [5:0] DIV16_TC = 6'h0F;
    localparam logic [5:0] DIV64_TC = 6'h3F;
endpackage : compact_timer_pkg

//--- verilog/compact_timer.sv
// Summary of operation
// [R1] Count high byte shows counter bits 9..8; upper bits read zero.
// [R2] Compare A value held in low and high bytes, both reset zero.
// [R3] Mode field: 00 compare output, 10 PWM, 11 timer/counter.
// [R4] Clear-select low: clear on P match or overflow, raising both flags; the code raises no A flag while compare A is zero.
// [R5] Clear-select high: clear on A match, only A flag, never P flag.
// [R6] Clear-select high with A zero: run to 3FF, no A flag.
// [R7] Compare mode pin changes only on A match, never on P match.
// [R8] On A match pin goes high, low or toggles; code zero keeps it.
// [R9] Timer on rising edge sets pin to output-control initial level.
// [R10] Timer/counter mode counts and flags like compare but leaves pin free.
// [R11] PWM ignores clear-select; swap bit picks period and duty register.
// [R12] PWM raises A flag on A match and P flag on P match.
// [R13] PWM: output-control picks active level, polarity inverts, pin function.
// [R14] PWM counting runs on while the pin is forced inactive or active.
// [R15] Swap clear: period is code times 128 (0 gives 1024), duty A.
// [R16] Duty at or above period gives 100 percent duty.
// [R17] Swap set: period from A, duty code times 128 (0 gives 1024).
// [R18] Timer on rising clears counter; turning off keeps the count.
// [R19] Comparator P compares code with counter bits 9..7.
// [R20] Pin codes per mode: compare low/high/toggle; PWM inactive/active/wave.
// [R21] Pause freezes the counter; clearing it resumes from that value.
// [R22] Match flags are sticky until software clears them.
// [R23] Software stops the timer before changing mode or pin function.
`timescale 1ns/1ps
module compact_timer (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic RST_N,
    // Avalon-MM slave
    input wire logic [7:0] ADDRESS,
    input wire logic READ,
    input wire logic WRITE,
    input wire logic [31:0] WRITEDATA,
    input wire logic [3:0] BYTEENABLE,
    output logic [31:0] READDATA,
    output logic WAITREQUEST,
    // Timer pin
    output logic PIN_OUT,
    output logic PIN_OE
);

    logic [7:0] ctrl0_ff;
    logic [7:0] ctrl1_ff;
    logic [9:0] cmp_a_ff;
    logic [9:0] count_ff;
    logic [5:0] pre_ff;
    logic on_prev_ff;
    logic flag_a_ff;
    logic flag_p_ff;
    logic cm_level_ff;
    logic pin_ff;
    logic oe_ff;
    logic wait_ff;
    logic [31:0] rdata_ff;

    logic on_bit;
    logic pause_bit;
    logic [2:0] per_code;
    compact_timer_pkg::mode_t mode;
    logic [1:0] pin_fn;
    logic oc_bit;
    logic pol_bit;
    logic dpx_bit;
    logic cclr_bit;
    logic on_rise;
    logic tick;
    logic [2:0] clk_sel;
    logic [5:0] pre_tc;
    logic [9:0] p_base;
    logic [9:0] p_end;
    logic [9:0] a_end;
    logic [10:0] p_len;
    logic [10:0] duty;
    logic a_evt;
    logic p_evt;
    logic clr_evt;
    logic pwm_act;
    logic wr_ok;
    logic rd_req;
    logic [31:0] rd_val;
    logic nxt_pin;

    // Field decode
    assign on_bit = ctrl0_ff[compact_timer_pkg::C0_ON];
    assign pause_bit = ctrl0_ff[compact_timer_pkg::C0_PAUSE];
    assign per_code = ctrl0_ff[compact_timer_pkg::C0_PER_HI:0];
    assign mode = compact_timer_pkg::mode_t'(
        ctrl1_ff[compact_timer_pkg::C1_MODE_HI:compact_timer_pkg::C1_MODE_LO]);
    assign pin_fn =
        ctrl1_ff[compact_timer_pkg::C1_PF_HI:compact_timer_pkg::C1_PF_LO];
    assign oc_bit = ctrl1_ff[compact_timer_pkg::C1_OC];
    assign pol_bit = ctrl1_ff[compact_timer_pkg::C1_POL];
    assign dpx_bit = ctrl1_ff[compact_timer_pkg::C1_DPX];
    assign cclr_bit = ctrl1_ff[compact_timer_pkg::C1_CCLR];
    assign on_rise = on_bit && !on_prev_ff;

    // Counter clock select; the external pin clock is not wired here
    assign clk_sel =
        ctrl0_ff[compact_timer_pkg::C0_CKS_HI:compact_timer_pkg::C0_CKS_LO];

    always_comb begin
        case (clk_sel)
            3'b000: pre_tc = compact_timer_pkg::DIV4_TC;
            3'b001: pre_tc = compact_timer_pkg::DIV1_TC;
            3'b010: pre_tc = compact_timer_pkg::DIV16_TC;
            3'b011: pre_tc = compact_timer_pkg::DIV64_TC;
            default: pre_tc = compact_timer_pkg::DIV1_TC;
        endcase
    end

    // Prescaler restarts with the timer so the first count is a full one
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            pre_ff <= '0;
        end else if (on_rise || pre_ff >= pre_tc) begin
            pre_ff <= '0;
        end else if (on_bit && !pause_bit) begin
            pre_ff <= pre_ff + 6'h01;
        end
    end

    assign tick = on_bit && !pause_bit && !on_rise && (pre_ff >= pre_tc);

    // Period code against top counter bits; zero wraps to 3FF
    assign p_base = {per_code, 7'h00}; // R19
    assign p_end = p_base - 10'h001; // R19
    assign p_len = (per_code == 3'b000) ? 11'h400 : {1'b0, p_base}; // R15
    assign a_end = cmp_a_ff - 10'h001;

    // Match events and clear source per mode
    always_comb begin
        a_evt = 1'b0;
        p_evt = 1'b0;
        clr_evt = 1'b0;
        duty = 11'h000;
        if (mode == compact_timer_pkg::MODE_PWM) begin
            // Clear-select plays no part here
            if (!dpx_bit) begin // R11
                p_evt = tick && (count_ff == p_end); // R12
                a_evt = tick && (count_ff == cmp_a_ff); // R12
                clr_evt = p_evt; // R15
                duty = {1'b0, cmp_a_ff}; // R15
            end else begin
                a_evt = tick && (count_ff == a_end); // R12
                p_evt = tick && (count_ff == p_base); // R12
                clr_evt = a_evt; // R17
                duty = p_len; // R17
            end
        end else if (cclr_bit) begin
            // A of zero lets the counter wrap at 3FF with no flag
            a_evt = tick && (cmp_a_ff != 10'h000)
                && (count_ff == cmp_a_ff); // R5 R6
            clr_evt = a_evt; // R5
        end else begin
            a_evt = tick && (cmp_a_ff != 10'h000)
                && (count_ff == cmp_a_ff); // R4
            p_evt = tick && (count_ff == p_end); // R4
            clr_evt = p_evt; // R4
        end
    end

    // Up counter; off or paused keeps the residual value
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            count_ff <= compact_timer_pkg::CNT_RST;
        end else if (on_rise) begin
            count_ff <= compact_timer_pkg::CNT_RST; // R18
        end else if (clr_evt) begin
            count_ff <= compact_timer_pkg::CNT_RST; // R4
        end else if (tick) begin
            count_ff <= count_ff + 10'h001; // R21
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            on_prev_ff <= 1'b0;
        end else begin
            on_prev_ff <= on_bit;
        end
    end

    // Sticky flags; a new match wins over a software clear
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            flag_a_ff <= 1'b0;
            flag_p_ff <= 1'b0;
        end else begin
            if (a_evt) begin
                flag_a_ff <= 1'b1; // R22
            end else if (wr_ok && ADDRESS == compact_timer_pkg::OFF_FLAGS
                    && WRITEDATA[compact_timer_pkg::FL_A]) begin
                flag_a_ff <= 1'b0;
            end
            if (p_evt) begin
                flag_p_ff <= 1'b1; // R22
            end else if (wr_ok && ADDRESS == compact_timer_pkg::OFF_FLAGS
                    && WRITEDATA[compact_timer_pkg::FL_P]) begin
                flag_p_ff <= 1'b0;
            end
        end
    end

    // Compare-mode pin level, steered only by comparator A
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            cm_level_ff <= 1'b0;
        end else if (on_rise) begin
            cm_level_ff <= oc_bit; // R9
        end else if (a_evt && mode == compact_timer_pkg::MODE_CMP) begin // R7
            case (pin_fn)
                compact_timer_pkg::PF_LOW: cm_level_ff <= 1'b0; // R8 R20
                compact_timer_pkg::PF_HIGH: cm_level_ff <= 1'b1; // R8 R20
                compact_timer_pkg::PF_TOGGLE: cm_level_ff <= !cm_level_ff; // R8
                default: cm_level_ff <= cm_level_ff; // R8
            endcase
        end
    end

    // Duty compare keeps running whatever the pin function
    assign pwm_act = ({1'b0, count_ff} < duty); // R14 R16

    // Pin level per mode, polarity applied last
    always_comb begin
        case (mode)
            compact_timer_pkg::MODE_CMP: nxt_pin = cm_level_ff ^ pol_bit;
            compact_timer_pkg::MODE_PWM: begin
                case (pin_fn)
                    compact_timer_pkg::PF_ACT:
                        nxt_pin = oc_bit ^ pol_bit; // R13
                    compact_timer_pkg::PF_PWM:
                        nxt_pin = !(pwm_act ^ oc_bit) ^ pol_bit; // R13 R20
                    default: nxt_pin = !oc_bit ^ pol_bit; // R13 R20
                endcase
            end
            default: nxt_pin = 1'b0;
        endcase
    end

    // Pin outputs; timer/counter mode releases the pin
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            pin_ff <= 1'b0;
            oe_ff <= 1'b0;
        end else begin
            pin_ff <= nxt_pin;
            oe_ff <= (mode == compact_timer_pkg::MODE_CMP)
                || (mode == compact_timer_pkg::MODE_PWM); // R3 R10
        end
    end

    // Bus: one wait cycle, the access completes when waitrequest is low
    assign wr_ok = WRITE && !wait_ff && BYTEENABLE[0];
    assign rd_req = (READ || WRITE) && wait_ff;

    always_comb begin
        rd_val = 32'h0000_0000;
        case (ADDRESS)
            compact_timer_pkg::OFF_CTRL0: rd_val[7:0] = ctrl0_ff;
            compact_timer_pkg::OFF_CTRL1: rd_val[7:0] = ctrl1_ff;
            compact_timer_pkg::OFF_CNT_LO: rd_val[7:0] = count_ff[7:0];
            compact_timer_pkg::OFF_CNT_HI: rd_val[1:0] = count_ff[9:8]; // R1
            compact_timer_pkg::OFF_CMPA_LO: rd_val[7:0] = cmp_a_ff[7:0]; // R2
            compact_timer_pkg::OFF_CMPA_HI: rd_val[1:0] = cmp_a_ff[9:8]; // R2
            compact_timer_pkg::OFF_FLAGS: rd_val[1:0] = {flag_p_ff, flag_a_ff};
            default: rd_val = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            wait_ff <= 1'b1;
            rdata_ff <= 32'h0000_0000;
        end else if (rd_req) begin
            wait_ff <= 1'b0;
            rdata_ff <= READ ? rd_val : 32'h0000_0000;
        end else begin
            wait_ff <= 1'b1;
            rdata_ff <= 32'h0000_0000;
        end
    end

    // Software-written registers; counter bytes are read-only
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            ctrl0_ff <= compact_timer_pkg::CTRL_RST;
            ctrl1_ff <= compact_timer_pkg::CTRL_RST;
            cmp_a_ff <= compact_timer_pkg::CNT_RST; // R2
        end else if (wr_ok) begin
            case (ADDRESS)
                compact_timer_pkg::OFF_CTRL0: ctrl0_ff <= WRITEDATA[7:0];
                compact_timer_pkg::OFF_CTRL1: ctrl1_ff <= WRITEDATA[7:0];
                compact_timer_pkg::OFF_CMPA_LO:
                    cmp_a_ff[7:0] <= WRITEDATA[7:0]; // R2
                compact_timer_pkg::OFF_CMPA_HI:
                    cmp_a_ff[9:8] <= WRITEDATA[1:0]; // R2
                default: ctrl0_ff <= ctrl0_ff;
            endcase
        end
    end

    assign READDATA = rdata_ff;
    assign WAITREQUEST = wait_ff;
    assign PIN_OUT = pin_ff;
    assign PIN_OE = oe_ff;

    // Checks
    sequence s_rise;
        $rose(on_bit);
    endsequence

    sequence s_hi_read;
        READ && !wait_ff && ADDRESS == compact_timer_pkg::OFF_CNT_HI;
    endsequence

    property p_cnt_hi_zero;
        @(posedge CLOCK) disable iff (!RST_N)
        s_hi_read |-> READDATA[31:2] == 30'h0000_0000
            && READDATA[1:0] == $past(count_ff[9:8]);
    endproperty
    a_cnt_hi_zero: assert property (p_cnt_hi_zero) // R1
        else $error("count high byte upper bits not zero");

    property p_on_clear;
        @(posedge CLOCK) disable iff (!RST_N)
        s_rise |=> count_ff == 10'h000 && cm_level_ff == $past(oc_bit);
    endproperty
    a_on_clear: assert property (p_on_clear) // R18 R9
        else $error("timer start did not clear counter or set level");

    property p_pause_hold;
        @(posedge CLOCK) disable iff (!RST_N)
        (pause_bit && !on_rise) |=> $stable(count_ff);
    endproperty
    a_pause_hold: assert property (p_pause_hold) // R21
        else $error("counter moved while paused");

    property p_no_p_flag;
        @(posedge CLOCK) disable iff (!RST_N)
        (cclr_bit && mode != compact_timer_pkg::MODE_PWM) |-> !p_evt;
    endproperty
    a_no_p_flag: assert property (p_no_p_flag) // R5
        else $error("P match raised with clear-select high");

    property p_a_zero;
        @(posedge CLOCK) disable iff (!RST_N)
        (cclr_bit && cmp_a_ff == 10'h000
            && mode != compact_timer_pkg::MODE_PWM
            && tick && count_ff == 10'h3FF)
            |=> count_ff == 10'h000 && !$rose(flag_a_ff);
    endproperty
    a_a_zero: assert property (p_a_zero) // R6
        else $error("A of zero did not wrap cleanly");

    property p_pin_hold;
        @(posedge CLOCK) disable iff (!RST_N)
        (!a_evt && !on_rise) |=> $stable(cm_level_ff);
    endproperty
    a_pin_hold: assert property (p_pin_hold) // R7
        else $error("compare level moved without A match");

    property p_tmr_free;
        @(posedge CLOCK) disable iff (!RST_N)
        (mode == compact_timer_pkg::MODE_TMR) |=> !PIN_OE;
    endproperty
    a_tmr_free: assert property (p_tmr_free) // R10
        else $error("pin driven in timer mode");

    property p_flag_set;
        @(posedge CLOCK) disable iff (!RST_N)
        (a_evt or p_evt) |=> (flag_a_ff || !$past(a_evt))
            && (flag_p_ff || !$past(p_evt));
    endproperty
    a_flag_set: assert property (p_flag_set) // R22
        else $error("match flag not set");

    property p_full_duty;
        @(posedge CLOCK) disable iff (!RST_N)
        (mode == compact_timer_pkg::MODE_PWM
            && pin_fn == compact_timer_pkg::PF_PWM
            && !dpx_bit && {1'b0, cmp_a_ff} >= p_len)
            |=> PIN_OUT == ($past(oc_bit) ^ $past(pol_bit));
    endproperty
    a_full_duty: assert property (p_full_duty) // R16
        else $error("PWM not at full duty");

endmodule : compact_timer

//--- verif/pin_load.sv
`timescale 1ns/1ps
module pin_load (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Timer pin
    input wire logic pin_out,
    input wire logic pin_oe,
    // Measurement window and results
    input wire logic meas_en,
    output logic level,
    output logic [15:0] hi_cnt,
    output logic [15:0] rise_cnt
);
    logic prev_ff;
    logic en_ff;

    // Pull-down on the load: a released pin reads low, never the old level
    assign level = pin_oe ? pin_out : 1'b0;

    // High time and rising edges seen inside the window
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_ff <= 1'b0;
            en_ff <= 1'b0;
            hi_cnt <= 16'h0000;
            rise_cnt <= 16'h0000;
        end else begin
            prev_ff <= level;
            en_ff <= meas_en;
            if (meas_en && !en_ff) begin
                hi_cnt <= {15'h0000, level};
                rise_cnt <= {15'h0000, level & ~prev_ff};
            end else if (meas_en) begin
                hi_cnt <= hi_cnt + {15'h0000, level};
                rise_cnt <= rise_cnt + {15'h0000, level & ~prev_ff};
            end
        end
    end
endmodule : pin_load

//--- verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic CLOCK = 1'b0;
    logic RST_N = 1'b0;
    logic [7:0] ADDRESS = 8'h00;
    logic READ = 1'b0;
    logic WRITE = 1'b0;
    logic [31:0] WRITEDATA = 32'h0000_0000;
    logic [3:0] BYTEENABLE = 4'h1;
    logic [31:0] READDATA;
    logic WAITREQUEST;
    logic PIN_OUT;
    logic PIN_OE;
    logic meas_en = 1'b0;
    logic level;
    logic [15:0] hi_cnt;
    logic [15:0] rise_cnt;
    logic [31:0] rd_val;
    logic [9:0] y;
    logic [9:0] z;
    int miscompares = 0;
    int cmp_count = 0;
    int cyc = 0;
    // Case table: control 1, period code, compare A, window, results
    logic [7:0] t_c1 [15] = '{8'h09, 8'h01, 8'h19, 8'h21, 8'h31, 8'h31,
        8'h30, 8'hF0, 8'hA9, 8'hA8, 8'hA0, 8'hAC, 8'h88, 8'h98, 8'hAA};
    logic [2:0] t_per [15] = '{0, 0, 0, 0, 0, 0, 1, 1, 1, 1, 1, 1, 1, 1, 1};
    logic [9:0] t_a [15] = '{5, 5, 5, 5, 5, 0, 5, 5, 32, 200, 32, 32, 32,
        32, 200};
    int t_win [15] = '{100, 100, 100, 100, 600, 1100, 512, 100, 512, 512,
        512, 512, 512, 512, 800};
    logic [15:0] t_hi [15] = '{100, 0, 0, 100, 300, 0, 256, 0, 128, 512,
        384, 384, 0, 512, 512};
    logic [15:0] t_rise [15] = '{0, 0, 0, 0, 50, 0, 2, 0, 4, 0, 4, 4, 0, 0,
        4};
    logic [1:0] t_flg [15] = '{1, 1, 1, 1, 1, 0, 3, 3, 3, 2, 3, 3, 3, 3, 3};

    compact_timer i_compact_timer (
        .CLOCK(CLOCK),
        .RST_N(RST_N),
        .ADDRESS(ADDRESS),
        .READ(READ),
        .WRITE(WRITE),
        .WRITEDATA(WRITEDATA),
        .BYTEENABLE(BYTEENABLE),
        .READDATA(READDATA),
        .WAITREQUEST(WAITREQUEST),
        .PIN_OUT(PIN_OUT),
        .PIN_OE(PIN_OE)
    );

    pin_load i_pin_load (
        .clk(CLOCK),
        .rst_n(RST_N),
        .pin_out(PIN_OUT),
        .pin_oe(PIN_OE),
        .meas_en(meas_en),
        .level(level),
        .hi_cnt(hi_cnt),
        .rise_cnt(rise_cnt)
    );

    // 100 MHz system clock
    always #5 CLOCK = ~CLOCK;

    task end_sim;
        $display("counts: compares %0d mismatches %0d", cmp_count,
            miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_sim

    // Hang guard, about two and a half times the twelve and a half thousand cycles the tests need
    always @(posedge CLOCK) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            miscompares++;
            $display("mismatch at %0t: timeout", $time);
            end_sim;
        end
    end

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Avalon access; read just after the rising edge, waitrequest still
    // shows what the design drove through the cycle that just ended
    task bus(input logic is_wr, input logic [7:0] a, input logic [7:0] d);
        ADDRESS <= a;
        WRITEDATA <= {24'h00_0000, d};
        WRITE <= is_wr;
        READ <= !is_wr;
        @(posedge CLOCK);
        while (WAITREQUEST !== 1'b0) @(posedge CLOCK);
        rd_val = READDATA;
        WRITE <= 1'b0;
        READ <= 1'b0;
        // Extra edge so back-to-back calls never assign a strobe twice
        @(posedge CLOCK);
    endtask : bus

    task wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask : wr

    task rd(input logic [7:0] a);
        bus(1'b0, a, 8'h00);
    endtask : rd

    // Counter read; only coherent while the count is frozen
    task rdcnt(output logic [9:0] c);
        rd(8'h08);
        c[7:0] = rd_val[7:0];
        rd(8'h0C);
        chk(rd_val & 32'hFFFF_FFFC, 32'h0000_0000);
        c[9:8] = rd_val[1:0];
    endtask : rdcnt

    // Reconfigure only with the timer stopped, then switch it on
    task run(input logic [7:0] c1, input logic [2:0] per, input logic [9:0] a);
        wr(8'h00, {4'b0001, 1'b0, per});
        wr(8'h10, a[7:0]);
        wr(8'h14, {6'b00_0000, a[9:8]});
        wr(8'h04, c1);
        wr(8'h18, 8'h03);
        wr(8'h00, {4'b0001, 1'b1, per});
    endtask : run

    initial begin
        repeat (16) @(posedge CLOCK);
        RST_N <= 1'b1;
        @(posedge CLOCK);
        // Reset values, read-only and unmapped places
        rd(8'h10);
        chk(rd_val, 32'h0000_0000);
        rd(8'h14);
        chk(rd_val, 32'h0000_0000);
        rd(8'h0C);
        chk(rd_val, 32'h0000_0000);
        wr(8'h14, 8'hFF);
        rd(8'h14);
        chk(rd_val, 32'h0000_0003);
        wr(8'h10, 8'hA5);
        rd(8'h10);
        chk(rd_val, 32'h0000_00A5);
        // Lane 0 off: the write must leave the byte alone
        BYTEENABLE <= 4'h0;
        wr(8'h10, 8'h3C);
        BYTEENABLE <= 4'h1;
        rd(8'h10);
        chk(rd_val, 32'h0000_00A5);
        wr(8'h0C, 8'hFF);
        rd(8'h0C);
        chk(rd_val, 32'h0000_0000);
        rd(8'h1C);
        chk(rd_val, 32'h0000_0000);
        $display("test registers done");
        // Mode cases: pin enable, high time, edges and flags
        for (int i = 0; i < 15; i++) begin
            run(t_c1[i], t_per[i], t_a[i]);
            repeat (300) @(posedge CLOCK);
            meas_en <= 1'b1;
            repeat (t_win[i]) @(posedge CLOCK);
            meas_en <= 1'b0;
            @(posedge CLOCK);
            chk({16'h0000, hi_cnt}, {16'h0000, t_hi[i]});
            chk({16'h0000, rise_cnt}, {16'h0000, t_rise[i]});
            chk({31'h0, PIN_OE}, {31'h0, t_c1[i][7:6] != 2'b11});
            rd(8'h18);
            chk(rd_val, {30'h0, t_flg[i]});
            $display("test mode case %0d done", i);
        end
        // Pause, off and restart behaviour of the counter
        wr(8'h00, 8'h10);
        wr(8'h18, 8'h03);
        rd(8'h18);
        chk(rd_val, 32'h0000_0000);
        wr(8'h04, 8'hF0);
        wr(8'h00, 8'h98);
        rdcnt(y);
        chk({22'h0, y}, 32'h0000_0000);
        wr(8'h00, 8'h18);
        repeat (400) @(posedge CLOCK);
        wr(8'h00, 8'h98);
        rdcnt(y);
        chk({31'h0, y[9:8] != 2'b00}, 32'h0000_0001);
        repeat (50) @(posedge CLOCK);
        rdcnt(z);
        chk({22'h0, z}, {22'h0, y});
        wr(8'h00, 8'h18);
        repeat (20) @(posedge CLOCK);
        wr(8'h00, 8'h10);
        rdcnt(z);
        chk({31'h0, z > y}, 32'h0000_0001);
        repeat (50) @(posedge CLOCK);
        rdcnt(y);
        chk({22'h0, y}, {22'h0, z});
        wr(8'h00, 8'h98);
        rdcnt(y);
        chk({22'h0, y}, 32'h0000_0000);
        // Divide-by-four clock: 400 system clocks give 100 counts
        wr(8'h00, 8'h08);
        repeat (400) @(posedge CLOCK);
        wr(8'h00, 8'h88);
        rdcnt(y);
        chk({22'h0, y}, 32'h0000_0064);
        $display("test pause and restart done");
        end_sim;
    end
endmodule : tb_top
